// file: mtw_target.sv
// Two-wire bus target with strap address capture, alert flags and pointer.
// Assumes open-drain pads outside and a register store answering reg_rdata_i.
`timescale 1ns/1ps
`default_nettype none
module mtw_target
	import mtw_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = BUS_TIMEOUT_CYC
) (
	input  wire logic               clk_i,
	input  wire logic               rst_b_i,
	input  wire logic               scl_clk_i,
	input  wire logic               scl_i,
	input  wire logic               sda_i,
	output var  logic               sda_o,
	output var  logic               sda_oe_o,
	input  wire logic               strap_pin_low_i,
	output var  logic               strap_pin_low_o,
	output var  logic               strap_pin_low_oe_o,
	input  wire logic               strap_pin_high_i,
	output var  logic               strap_pin_high_o,
	output var  logic               strap_pin_high_oe_o,
	input  wire logic               power_down_pin_i,
	input  wire logic               timeout_en_i,
	input  wire logic               byte_count_en_i,
	input  wire logic [1:0]         pin_fn_low_i,
	input  wire logic [1:0]         pin_fn_high_i,
	input  wire logic [1:0]         gpio_out_i,
	output var  logic [1:0]         gpio_in_o,
	output var  logic               slow_o,
	input  wire logic [ALERT_W-1:0] alert_trig_i,
	input  wire logic [ALERT_W-1:0] alert_cond_i,
	input  wire logic [ALERT_W-1:0] alert_en_i,
	input  wire logic               conv_done_i,
	output var  logic [ALERT_W-1:0] alert_flags_o,
	output var  logic               addr_fixed_o,
	output var  logic [6:0]         target_addr_o,
	output var  logic [7:0]         reg_ptr_o,
	output var  logic [2:0]         reg_idx_o,
	input  wire logic [7:0]         reg_rdata_i,
	output var  logic               reg_rd_o,
	output var  logic               reg_wr_o,
	output var  logic [7:0]         reg_wdata_o
);
	import mtw_pkg::*;
	localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);
	localparam logic [TW-1:0] TMO_MAX = TW'(TIMEOUT_CYC);

	logic       rst_m, rst_b_s;
	logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic       lo_m, lo_s, hi_m, hi_s, pd_m, pd_s, lnk_m, lnk_s, lnk_done;
	logic       lrst_b_r, arm_r;
	logic       scl_rise, scl_fall, start_det, stop_det, tmo_hit, load, addr_hit;
	logic [7:0] tx_byte;
	logic       send_cnt;

	// Reset: asserted at once, released through two flip-flops
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_m   <= 1'b0;
			rst_b_s <= 1'b0;
		end else begin
			rst_m   <= 1'b1;
			rst_b_s <= rst_m;
		end
	end

	// Pin synchronisers; the third stage serves edge detection and the stable-data check of the strap capture
	always_ff @(posedge clk_i or negedge rst_b_s) begin
		if (!rst_b_s) begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
			{lo_m, lo_s, hi_m, hi_s, pd_m, pd_s, lnk_m, lnk_s} <= 8'h00;
			lrst_b_r <= 1'b0;
			arm_r    <= 1'b0;
		end else begin
			{scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
			{lo_m, lo_s} <= {strap_pin_low_i, lo_m};
			{hi_m, hi_s} <= {strap_pin_high_i, hi_m};
			{pd_m, pd_s} <= {power_down_pin_i, pd_m};
			{lnk_m, lnk_s} <= {lnk_done, lnk_m};
			lrst_b_r <= ~pd_s;  // Power-down restarts the cycle count
			// Straps are watched only once their synchronisers hold real pin levels
			arm_r    <= lrst_b_r;
		end
	end

	// Bus conditions; 200 MHz sampling keeps up with a 3.4 MHz bus clock
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

	mtw_scl_count u_scl_count (
		.lnk_clk_i   (scl_clk_i),
		.lnk_rst_b_i (lrst_b_r),
		.done_o      (lnk_done)
	);

	// ---- Address capture ----
	logic [1:0] lo_seen_r, lo_seen_nxt, hi_seen_r, hi_seen_nxt;
	logic [1:0] nsda_r, nsda_nxt;
	logic [3:0] code_r, code_nxt;
	logic       fixed_r, fixed_nxt;
	logic [1:0] pin_s;

	// Strap code from what the pin did while the straps were watched
	function automatic logic [1:0] classify(input logic seen_lo, input logic seen_hi, input logic ne_sda);
		if (!seen_hi)
			classify = STRAP_GND;
		else if (!seen_lo)
			classify = STRAP_PULLUP;
		else if (!ne_sda)
			classify = STRAP_SDA;
		else
			classify = STRAP_SCL;
	endfunction : classify

	assign pin_s = {hi_s, lo_s};

	// Watch straps until three bus cycles have passed, then freeze the code
	always_comb begin
		lo_seen_nxt = lo_seen_r;
		hi_seen_nxt = hi_seen_r;
		nsda_nxt    = nsda_r;
		code_nxt    = code_r;
		fixed_nxt   = fixed_r;
		if (pd_s) begin
			lo_seen_nxt = 2'h0;
			hi_seen_nxt = 2'h0;
			nsda_nxt    = 2'h0;
			fixed_nxt   = 1'b0;
		end else if (!fixed_r && arm_r) begin  // Reset values of the strap chains are no evidence
			lo_seen_nxt = lo_seen_r | ~pin_s;
			hi_seen_nxt = hi_seen_r | pin_s;
			// Sync chains of one net may skew by a cycle, so compare on stable data only
			if (sda_s == sda_d)
				nsda_nxt = nsda_r | (pin_s ^ {2{sda_s}});
			if (lnk_s) begin
				fixed_nxt = 1'b1;
				code_nxt  = {classify(lo_seen_nxt[1], hi_seen_nxt[1], nsda_nxt[1]),
					classify(lo_seen_nxt[0], hi_seen_nxt[0], nsda_nxt[0])};
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_s) begin
		if (!rst_b_s) begin
			lo_seen_r <= 2'h0;
			hi_seen_r <= 2'h0;
			nsda_r    <= 2'h0;
			code_r    <= 4'h0;
			fixed_r   <= 1'b0;
		end else begin
			lo_seen_r <= lo_seen_nxt;
			hi_seen_r <= hi_seen_nxt;
			nsda_r    <= nsda_nxt;
			code_r    <= code_nxt;
			fixed_r   <= fixed_nxt;
		end
	end

	assign addr_fixed_o  = fixed_r;
	assign target_addr_o = {ADDR_PREFIX, code_r};

	// ---- Clock-low timeout ----
	logic [TW-1:0] tmo_r, tmo_nxt;

	always_comb begin
		if (!timeout_en_i || scl_s)
			tmo_nxt = '0;
		else if (tmo_r != TMO_MAX)
			tmo_nxt = tmo_r + TW'(1);
		else
			tmo_nxt = tmo_r;
	end

	always_ff @(posedge clk_i or negedge rst_b_s) begin
		if (!rst_b_s)
			tmo_r <= '0;
		else
			tmo_r <= tmo_nxt;
	end

	assign tmo_hit = (tmo_r == TMO_MAX);

	// ---- Alert flags ----
	logic [ALERT_W-1:0] flags_r, flags_nxt, flag_set, flag_clr;

	// Set wins over a read that clears in the same cycle
	always_comb begin
		flag_set  = {ALERT_W{fixed_r}} & alert_en_i
			& (alert_trig_i | (alert_cond_i & {ALERT_W{conv_done_i}}));
		flag_clr  = '0;
		if (load && !send_cnt && reg_ptr_o == REG_ALERT)
			flag_clr = (reg_idx_o == 3'h0) ? {8'hff, 8'h00} : {8'h00, 8'hff};
		flags_nxt = (flags_r & ~flag_clr) | flag_set;
	end

	always_ff @(posedge clk_i or negedge rst_b_s) begin
		if (!rst_b_s)
			flags_r <= '0;
		else
			flags_r <= flags_nxt;
	end

	assign alert_flags_o = flags_r;

	// ---- Protocol engine ----
	mtw_state_t st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, wdat_r, wdat_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic       dir_r, dir_nxt, pset_r, pset_nxt, cnt_r, cnt_nxt, cntb_r, cntb_nxt;
	logic       oe_r, oe_nxt, wr_r, wr_nxt, rdp_r, rdp_nxt;

	// The alert response address never matches: every own address starts 100
	assign addr_hit = (fixed_r && sh_r[7:1] == target_addr_o)
		|| (sh_r[7:1] == GEN_CALL_ADDR && !sh_r[0]);
	assign send_cnt = byte_count_en_i && !cnt_r && idx_r == 3'h0;
	assign tx_byte  = send_cnt ? {5'h00, reg_size(ptr_r)}
		: (ptr_r == REG_ALERT) ? (idx_r == 3'h0 ? flags_r[15:8] : flags_r[7:0]) : reg_rdata_i;

	// Bits are sampled on rising and driven on falling bus clock edges
	always_comb begin
		st_nxt   = st_r;
		bit_nxt  = bit_r;
		sh_nxt   = sh_r;
		ptr_nxt  = ptr_r;
		idx_nxt  = idx_r;
		dir_nxt  = dir_r;
		pset_nxt = pset_r;
		cnt_nxt  = cnt_r;
		cntb_nxt = cntb_r;
		oe_nxt   = oe_r;
		wdat_nxt = wdat_r;
		wr_nxt   = 1'b0;
		rdp_nxt  = 1'b0;
		load     = 1'b0;
		if (stop_det || tmo_hit) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else if (start_det) begin
			st_nxt  = ST_ADDR;
			bit_nxt = 4'h0;
			oe_nxt  = 1'b0;
		end else if (scl_rise) begin
			case (st_r)
				ST_ADDR, ST_RX: begin
					if (bit_r != 4'h8) begin
						sh_nxt  = {sh_r[6:0], sda_s};
						bit_nxt = bit_r + 4'h1;
					end
				end
				ST_TX_ACK: begin
					if (sda_s)
						st_nxt = ST_IGNORE;
					else if (!cntb_r) begin
						if (idx_r + 3'h1 >= reg_size(ptr_r)) begin
							ptr_nxt = rd_next(ptr_r);
							idx_nxt = 3'h0;
							cnt_nxt = 1'b0;
						end else
							idx_nxt = idx_r + 3'h1;
					end
				end
				default: ;
			endcase
		end else if (scl_fall) begin
			case (st_r)
				ST_ADDR: begin
					if (bit_r == 4'h8) begin
						if (addr_hit) begin
							st_nxt   = ST_ADDR_ACK;
							oe_nxt   = 1'b1;
							dir_nxt  = sh_r[0];
							pset_nxt = 1'b0;
						end else
							st_nxt = ST_IGNORE;
					end
				end
				ST_ADDR_ACK: begin
					bit_nxt = 4'h0;
					oe_nxt  = 1'b0;
					st_nxt  = ST_RX;
					load    = dir_r;
				end
				ST_RX: begin
					if (bit_r == 4'h8) begin
						st_nxt = ST_RX_ACK;
						if (!pset_r) begin
							if (sh_r <= REG_LAST) begin
								oe_nxt   = 1'b1;
								ptr_nxt  = sh_r;
								idx_nxt  = 3'h0;
								cnt_nxt  = 1'b0;
								pset_nxt = 1'b1;
							end  // Else left high
						end else begin
							oe_nxt   = 1'b1;
							wr_nxt   = 1'b1;
							wdat_nxt = sh_r;  // Byte index 0 is the MSB byte
							if (idx_r + 3'h1 >= reg_size(ptr_r)) begin
								ptr_nxt = wr_next(ptr_r);
								idx_nxt = 3'h0;
							end else
								idx_nxt = idx_r + 3'h1;
						end
					end
				end
				ST_RX_ACK: begin
					bit_nxt = 4'h0;
					oe_nxt  = 1'b0;
					st_nxt  = oe_r ? ST_RX : ST_IGNORE;
				end
				ST_TX: begin
					if (bit_r == 4'h8) begin
						oe_nxt = 1'b0;
						st_nxt = ST_TX_ACK;
					end else begin
						oe_nxt  = ~sh_r[7];
						sh_nxt  = {sh_r[6:0], 1'b0};
						bit_nxt = bit_r + 4'h1;
					end
				end
				ST_TX_ACK: load = 1'b1;
				default: ;
			endcase
			if (load) begin
				st_nxt   = ST_TX;
				bit_nxt  = 4'h1;
				oe_nxt   = ~tx_byte[7];
				sh_nxt   = {tx_byte[6:0], 1'b0};
				cntb_nxt = send_cnt;
				cnt_nxt  = cnt_r | send_cnt;
				rdp_nxt  = ~send_cnt;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_s) begin
		if (!rst_b_s) begin
			st_r   <= ST_IDLE;
			bit_r  <= 4'h0;
			sh_r   <= 8'h00;
			ptr_r  <= 8'h00;
			idx_r  <= 3'h0;
			dir_r  <= 1'b0;
			pset_r <= 1'b0;
			cnt_r  <= 1'b0;
			cntb_r <= 1'b0;
			oe_r   <= 1'b0;
			wdat_r <= 8'h00;
			wr_r   <= 1'b0;
			rdp_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			bit_r  <= bit_nxt;
			sh_r   <= sh_nxt;
			ptr_r  <= ptr_nxt;
			idx_r  <= idx_nxt;
			dir_r  <= dir_nxt;
			pset_r <= pset_nxt;
			cnt_r  <= cnt_nxt;
			cntb_r <= cntb_nxt;
			oe_r   <= oe_nxt;
			wdat_r <= wdat_nxt;
			wr_r   <= wr_nxt;
			rdp_r  <= rdp_nxt;
		end
	end

	assign sda_o       = 1'b0;
	assign sda_oe_o    = oe_r;
	assign reg_ptr_o   = ptr_r;
	assign reg_idx_o   = idx_r;
	assign reg_wr_o    = wr_r;
	assign reg_wdata_o = wdat_r;
	assign reg_rd_o    = rdp_r;

	// ---- Multifunction straps ----
	logic [1:0] ok, drv_nxt, drv_r, gpi_nxt;
	logic       slow_nxt;

	// Only a pulled-up strap may carry a function, and only once fixed
	always_comb begin
		ok[0]    = fixed_r && code_r[1:0] == STRAP_PULLUP;
		ok[1]    = fixed_r && code_r[3:2] == STRAP_PULLUP;
		drv_nxt  = 2'h0;
		gpi_nxt  = 2'h0;
		slow_nxt = 1'b0;
		if (ok[0]) begin
			drv_nxt[0] = (pin_fn_low_i == FN_ALERT && |flags_r)
				|| (pin_fn_low_i == FN_GPIO && !gpio_out_i[0]);
			gpi_nxt[0] = (pin_fn_low_i == FN_GPIO) && lo_s;
			slow_nxt   = (pin_fn_low_i == FN_SLOW) && lo_s;
		end
		if (ok[1]) begin
			drv_nxt[1] = (pin_fn_high_i == FN_ALERT && |flags_r)
				|| (pin_fn_high_i == FN_GPIO && !gpio_out_i[1]);
			gpi_nxt[1] = (pin_fn_high_i == FN_GPIO) && hi_s;
			slow_nxt   = slow_nxt || ((pin_fn_high_i == FN_SLOW) && hi_s);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_s) begin
		if (!rst_b_s) begin
			drv_r     <= 2'h0;
			gpio_in_o <= 2'h0;
			slow_o    <= 1'b0;
		end else begin
			drv_r     <= drv_nxt;
			gpio_in_o <= gpi_nxt;
			slow_o    <= slow_nxt;
		end
	end

	assign strap_pin_low_o     = 1'b0;
	assign strap_pin_high_o    = 1'b0;
	assign strap_pin_low_oe_o  = drv_r[0];
	assign strap_pin_high_oe_o = drv_r[1];

	// ---- Checks ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_s);

	sequence host_nack_s;
		st_r == ST_TX_ACK && scl_rise && sda_s && !stop_det && !start_det && !tmo_hit;
	endsequence

	flag_set_a: assert property (|flag_set |=> ((flags_r & $past(flag_set)) == $past(flag_set)))
		else $error("enabled alert did not set its flag");
	no_fn_early_a: assert property (!fixed_r |-> ##1 (!strap_pin_low_oe_o && !strap_pin_high_oe_o && !slow_o))
		else $error("strap function active before address fixed");
	addr_form_a: assert property (fixed_r |-> target_addr_o[6:4] == 3'h4)
		else $error("address prefix wrong");
	addr_hold_a: assert property (fixed_r && !pd_s |=> fixed_r && $stable(target_addr_o))
		else $error("fixed address changed");
	stop_idle_a: assert property (stop_det |=> st_r == ST_IDLE && !sda_oe_o)
		else $error("stop did not reset interface");
	ara_quiet_a: assert property (st_r == ST_ADDR && scl_fall && bit_r == 4'h8 && sh_r[7:1] == ALERT_RESP_ADDR
		&& !stop_det && !start_det |=> !sda_oe_o ##1 !sda_oe_o)
		else $error("alert response address answered");
	bad_reg_nack_a: assert property (st_r == ST_RX && !pset_r && scl_fall && bit_r == 4'h8 && sh_r > REG_LAST
		&& !stop_det && !start_det && !tmo_hit |=> st_r == ST_RX_ACK && !sda_oe_o)
		else $error("invalid register address acknowledged");
	nack_hold_a: assert property (host_nack_s |=> $stable(reg_ptr_o) && $stable(reg_idx_o))
		else $error("pointer moved on negative acknowledge");
	tmo_reset_a: assert property (tmo_hit |=> st_r == ST_IDLE)
		else $error("timeout did not reset interface");
	hiz_strap_a: assert property (fixed_r && code_r[1:0] != STRAP_PULLUP |=> !strap_pin_low_oe_o)
		else $error("non pulled-up strap driven");
endmodule : mtw_target
`default_nettype wire

// file: mtw_pkg.sv
// Constants, types and helpers of the two-wire target interface of the monitor.
// Assumes a 200 MHz core clock; register contents other than the alert flags live in the surrounding device.
package mtw_pkg;
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned BUS_TIMEOUT_MS  = 25;     // Least clock-low time
	localparam int unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int unsigned LINK_CYCLES     = 3;
	localparam int unsigned ALERT_W         = 16;
	localparam logic [2:0]  ADDR_PREFIX     = 3'h4;
	localparam logic [6:0]  GEN_CALL_ADDR   = 7'h00;
	localparam logic [6:0]  ALERT_RESP_ADDR = 7'h0c;
	localparam logic [1:0]  STRAP_GND       = 2'h0;
	localparam logic [1:0]  STRAP_PULLUP    = 2'h1;
	localparam logic [1:0]  STRAP_SDA       = 2'h2;
	localparam logic [1:0]  STRAP_SCL       = 2'h3;
	localparam logic [1:0]  FN_ALERT        = 2'h0;
	localparam logic [1:0]  FN_SLOW         = 2'h1;
	localparam logic [1:0]  FN_GPIO         = 2'h2;
	localparam logic [7:0]  REG_CONTROL     = 8'h01;
	localparam logic [7:0]  REG_ALERT       = 8'h11;
	localparam logic [7:0]  REG_SMBUS       = 8'h12;
	localparam logic [7:0]  REG_NEG_FSR     = 8'h13;
	localparam logic [7:0]  REG_SLOW        = 8'h16;
	localparam logic [7:0]  REG_LAST        = 8'h17;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ADDR    = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_RX      = 3'b011,
		ST_RX_ACK  = 3'b100,
		ST_TX      = 3'b101,
		ST_TX_ACK  = 3'b110,
		ST_IGNORE  = 3'b111
	} mtw_state_t;

	// Bytes held by each register
	function automatic logic [2:0] reg_size(input logic [7:0] a);
		case (a)
			8'h02, 8'h08, 8'h0d, 8'h0e: reg_size = 3'h4;
			8'h03:                      reg_size = 3'h7;
			8'h00, 8'h14, 8'h15:        reg_size = 3'h0;
			8'h10, 8'h12, 8'h13, 8'h16: reg_size = 3'h1;
			default:                    reg_size = 3'h2;
		endcase
	endfunction : reg_size

	// Read loop: every data and configuration register, refresh addresses skipped
	function automatic logic [7:0] rd_next(input logic [7:0] a);
		case (a)
			REG_NEG_FSR: rd_next = REG_SLOW;
			REG_LAST:    rd_next = REG_CONTROL;
			default:     rd_next = a + 8'h01;
		endcase
	endfunction : rd_next

	// Write loop: configuration registers only
	function automatic logic [7:0] wr_next(input logic [7:0] a);
		case (a)
			REG_CONTROL: wr_next = REG_SMBUS;
			REG_SMBUS:   wr_next = REG_NEG_FSR;
			REG_NEG_FSR: wr_next = REG_SLOW;
			default:     wr_next = REG_CONTROL;
		endcase
	endfunction : wr_next
endpackage : mtw_pkg

// file: mtw_scl_count.sv
// Counts the first bus clock cycles after power-on on the bus clock itself.
// Assumes the bus clock stands high while its reset is released.
`timescale 1ns/1ps
`default_nettype none
module mtw_scl_count
	import mtw_pkg::*;
(
	input  wire logic lnk_clk_i,
	input  wire logic lnk_rst_b_i,
	output var  logic done_o
);
	import mtw_pkg::*;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic       done_nxt;

	// Saturating count of rising bus clock edges
	always_comb begin
		cnt_nxt  = (cnt_r == 2'(LINK_CYCLES)) ? cnt_r : cnt_r + 2'd1;
		done_nxt = (cnt_nxt == 2'(LINK_CYCLES));
	end

	// Release is safe unsynchronised: the bus clock is idle at power-on
	always_ff @(posedge lnk_clk_i or negedge lnk_rst_b_i) begin
		if (!lnk_rst_b_i) begin
			cnt_r  <= 2'h0;
			done_o <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			done_o <= done_nxt;
		end
	end
endmodule : mtw_scl_count
`default_nettype wire

// file: mtw_host_model.sv
// Bus controller model: frames, bytes and acknowledge slots on the two wires.
// Assumes open-drain wires that the bench resolves with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module mtw_host_model #(
	parameter int HP = 14 // Link cycles per half bit, about 3 MHz
) (
	input  wire logic lnk_clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_o
);
	// Both lines released; the clock stands high between frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge lnk_clk_i);
	endtask : w
	// START, also a repeated START from a low clock
	task automatic start();
		w(HP / 2);
		sda_o <= 1'b1;
		w(HP / 2);
		scl_o <= 1'b1;
		w(HP);
		sda_o <= 1'b0;
		w(HP);
		scl_o <= 1'b0;
	endtask : start
	task automatic stop();
		w(HP / 2);
		sda_o <= 1'b0;
		w(HP / 2);
		scl_o <= 1'b1;
		w(HP);
		sda_o <= 1'b1;
		w(HP);
	endtask : stop
	// Data moves mid-low so its hold time beats spike suppression
	task automatic bit_x(input logic v, output logic s);
		w(HP / 2);
		sda_o <= v;
		w(HP / 2);
		scl_o <= 1'b1;
		w(HP);
		s = sda_i;
		scl_o <= 1'b0;
	endtask : bit_x
	// Byte MSB first, then the slot left free for the target
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i], s);
		end
		bit_x(1'b1, s);
		ack = ~s;
	endtask : wbyte
	task automatic rbyte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, b[i]);
		end
		bit_x(~ack, s);
	endtask : rbyte
endmodule : mtw_host_model
`default_nettype wire

// file: mtw_target_tb.sv
// Self-checking bench: strap addressing, pointer loops, alerts, timeout, pins.
// Assumes the host model file; the register store is modelled here.
`timescale 1ns/1ps
`default_nettype none
module mtw_target_tb;
	import mtw_pkg::*;
	localparam int unsigned TO = 200;
	logic        clk_i, lnk_clk, rst_b_i, scl_h, sda_h, sda_oe_o, slow_o, nw, ak_a, ak_p, ak_d;
	logic        strap_pin_low_oe_o, strap_pin_high_oe_o, timeout_en_i, byte_count_en_i;
	logic        conv_done_i, addr_fixed_o, reg_wr_o, reg_rd_o, sda_o, strap_pin_low_o, strap_pin_high_o, pd;
	logic [1:0]  c_lo, c_hi, lo, hi, pin_fn_low_i, pin_fn_high_i, gpio_out_i, gpio_in_o;
	logic [15:0] alert_trig_i, alert_cond_i, alert_en_i, alert_flags_o, ev;
	logic [6:0]  target_addr_o, a, pa;
	logic [7:0]  reg_ptr_o, reg_wdata_o, reg_rdata_i, pm;
	logic [2:0]  reg_idx_o;
	logic [31:0] rnd;
	logic [7:0]  q_exp[$], q_got[$];
	int          im, errors, cmp_count, n_rd, n_rde;
	wire         scl_w, sda_w, lo_w, hi_w;

	function automatic logic lvl(input logic [1:0] c, input logic oe, input logic d, input logic k);
		return c == STRAP_GND ? 1'b0 : c == STRAP_PULLUP ? ~oe : c == STRAP_SDA ? d : k;
	endfunction : lvl
	function automatic logic [2:0] sz(input logic [7:0] p);
		case (p)
			8'h02, 8'h08, 8'h0d, 8'h0e: return 3'h4;
			8'h03: return 3'h7;
			8'h10, 8'h12, 8'h13, 8'h16: return 3'h1;
			default: return 3'h2;
		endcase
	endfunction : sz
	function automatic logic [7:0] nrd(input logic [7:0] p);
		return p == 8'h13 ? 8'h16 : p == 8'h17 ? 8'h01 : p + 8'h01;
	endfunction : nrd
	function automatic logic [7:0] rv(input logic [7:0] p, input logic [2:0] i);
		return p ^ {i, 5'h00} ^ 8'h5a;
	endfunction : rv
	function automatic logic [15:0] nxt();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd[15:0];
	endfunction : nxt

	// Open-drain wires with pull-ups; each strap follows its coded connection
	assign scl_w = scl_h;
	assign sda_w = sda_h & (~sda_oe_o | sda_o);
	assign lo_w = lvl(c_lo, strap_pin_low_oe_o & ~strap_pin_low_o, sda_w, scl_w);
	assign hi_w = lvl(c_hi, strap_pin_high_oe_o & ~strap_pin_high_o, sda_w, scl_w);
	assign reg_rdata_i = rv(reg_ptr_o, reg_idx_o);

	mtw_target #(.TIMEOUT_CYC(TO)) uut (
		.clk_i, .rst_b_i, .scl_clk_i(scl_w), .scl_i(scl_w), .sda_i(sda_w), .sda_o, .sda_oe_o,
		.strap_pin_low_i(lo_w), .strap_pin_low_o, .strap_pin_low_oe_o,
		.strap_pin_high_i(hi_w), .strap_pin_high_o, .strap_pin_high_oe_o,
		.power_down_pin_i(pd), .timeout_en_i, .byte_count_en_i, .pin_fn_low_i, .pin_fn_high_i,
		.gpio_out_i, .gpio_in_o, .slow_o, .alert_trig_i, .alert_cond_i, .alert_en_i, .conv_done_i,
		.alert_flags_o, .addr_fixed_o, .target_addr_o, .reg_ptr_o, .reg_idx_o, .reg_rdata_i,
		.reg_rd_o, .reg_wr_o, .reg_wdata_o
	);
	mtw_host_model host (.lnk_clk_i(lnk_clk), .sda_i(sda_w), .scl_o(scl_h), .sda_o(sda_h));

	// Core clock, and a link clock of unrelated phase that times the bus bits
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		lnk_clk = 1'b0;
		#3.7;
		forever #6 lnk_clk = ~lnk_clk;
	end
	// Written bytes as the store would see them
	always @(posedge clk_i) begin
		if (reg_wr_o === 1'b1) q_got.push_back(reg_wdata_o);
		if (reg_rd_o === 1'b1) n_rd++;
	end

	// Compared at the falling edge so the design's updates have landed
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		@(negedge clk_i);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	task automatic do_rst();
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		c_lo <= lo;
		c_hi <= hi;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask : do_rst
	task automatic pulse(input logic [15:0] t, input logic cd);
		@(posedge clk_i);
		alert_trig_i <= t;
		conv_done_i <= cd;
		@(posedge clk_i);
		alert_trig_i <= 16'h0000;
		conv_done_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : pulse
	// Write: pointer byte then n random data bytes
	task automatic wr(input logic [6:0] ad, input logic [7:0] p, input int n);
		logic [7:0] d;
		host.start();
		host.wbyte({ad, 1'b0}, ak_a);
		host.wbyte(p, ak_p);
		for (int i = 0; i < n; i++) begin
			d = 8'(nxt());
			host.wbyte(d, ak_d);
			if (ak_d) q_exp.push_back(d);
		end
		host.stop();
	endtask : wr
	// Read after a pointer write; the last byte is refused, so the pointer must hold
	task automatic rd(input logic [6:0] ad, input logic [7:0] p, input int n);
		logic       k;
		logic [7:0] b;
		host.start();
		host.wbyte({ad, 1'b0}, k);
		host.wbyte(p, k);
		host.start();
		host.wbyte({ad, 1'b1}, k);
		pm = p;
		im = 0;
		nw = 1'b1;
		for (int i = 0; i < n; i++) begin
			host.rbyte(i < n - 1, b);
			if (byte_count_en_i && nw) begin
				chk(b, sz(pm));
				nw = 1'b0;
			end else begin
				chk(b, pm != REG_ALERT ? rv(pm, im[2:0]) : im == 0 ? ev[15:8] : ev[7:0]);
				n_rde++;
				if (i < n - 1) begin
					im++;
					if (im == sz(pm)) begin
						im = 0;
						pm = nrd(pm);
						nw = 1'b1;
					end
				end
			end
		end
		host.stop();
		chk({reg_ptr_o, 5'h00, reg_idx_o}, {pm, 5'h00, im[2:0]});
	endtask : rd

	// Watchdog well beyond the expected run
	initial begin
		#450_000;
		errors++;
		wrap_up();
	end
	// Main sequence
	initial begin
		rst_b_i = 1'b0;
		pd = 1'b0;
		{timeout_en_i, byte_count_en_i, conv_done_i} = 3'b000;
		{pin_fn_low_i, pin_fn_high_i, gpio_out_i} = {FN_ALERT, FN_ALERT, 2'h3};
		{alert_trig_i, alert_cond_i, alert_en_i} = {16'h0000, 16'h0000, 16'hffff};
		{c_lo, c_hi} = 4'h5;
		rnd = 32'h505e_51ee;
		errors = 0;
		cmp_count = 0;
		for (int k = 0; k < 5; k++) begin
			lo = (k == 4) ? 2'h1 : 2'(k);
			hi = (k == 4) ? 2'h1 : 2'(3 - k);
			a = {ADDR_PREFIX, hi, lo};
			do_rst();
			pulse(16'hffff, 1'b0);
			chk(alert_flags_o, 16'h0000);
			wr(a, REG_SMBUS, 1);
			chk({addr_fixed_o, ak_a, target_addr_o}, {2'b11, a});
			chk(reg_ptr_o, REG_NEG_FSR);
			ev = nxt() | 16'h0001;
			pulse(ev, 1'b0);
			chk(alert_flags_o, ev);
			chk({strap_pin_high_oe_o, strap_pin_low_oe_o}, {hi == STRAP_PULLUP, lo == STRAP_PULLUP});
			@(posedge clk_i);
			c_lo <= ~lo;
			wr(a, REG_SMBUS, 1);
			chk({ak_a, target_addr_o}, {1'b1, a});
			@(posedge clk_i);
			c_lo <= lo;
			$display("test strap %0d done", k);
		end
		// Power-down forgets the address; the next command captures it afresh
		for (int p = 0; p < 2; p++) begin
			pa = {a[6:2], p[0] ? lo : STRAP_GND};
			@(posedge clk_i);
			pd <= 1'b1;
			c_lo <= pa[1:0];
			repeat (4) @(posedge clk_i);
			pd <= 1'b0;
			repeat (8) @(posedge clk_i);
			wr(pa, REG_SMBUS, 1);
			chk({addr_fixed_o, ak_a, target_addr_o}, {2'b11, pa});
		end
		rd(a, REG_ALERT, 2);
		chk(alert_flags_o, 16'h0000);
		chk(strap_pin_low_oe_o, 1'b0);
		@(posedge clk_i);
		alert_en_i <= nxt();
		alert_cond_i <= nxt();
		pulse(16'h0000, 1'b1);
		chk(alert_flags_o, alert_cond_i & alert_en_i);
		$display("test alert clear done");
		wr(7'h46, REG_CONTROL, 0);
		chk(ak_a, 1'b0);
		wr(ALERT_RESP_ADDR, REG_CONTROL, 0);
		chk(ak_a, 1'b0);
		wr(GEN_CALL_ADDR, 8'h14, 0);
		chk(ak_a, 1'b1);
		wr(a, 8'h18, 1);
		chk({ak_a, ak_p}, 2'b10);
		wr(a, REG_SLOW, 2);
		chk({reg_ptr_o, 5'h00, reg_idx_o}, {REG_CONTROL, 8'h01});
		rd(a, REG_NEG_FSR, 5);
		@(posedge clk_i);
		byte_count_en_i <= 1'b1;
		rd(a, REG_SMBUS, 4);
		@(posedge clk_i);
		byte_count_en_i <= 1'b0;
		$display("test addressing and pointer done");
		// A clock held low drops the frame only when the timeout is on
		for (int t = 0; t < 2; t++) begin
			@(posedge clk_i);
			timeout_en_i <= t[0];
			host.start();
			host.wbyte({a, 1'b0}, ak_a);
			host.w(100);
			host.wbyte(REG_CONTROL, ak_p);
			host.stop();
			chk({ak_a, ak_p}, {1'b1, t == 0});
		end
		wr(a, REG_CONTROL, 0);
		chk({ak_a, ak_p}, 2'b11);
		$display("test timeout done");
		for (int g = 0; g < 2; g++) begin
			@(posedge clk_i);
			pin_fn_low_i <= FN_SLOW;
			pin_fn_high_i <= FN_GPIO;
			gpio_out_i <= {g[0], 1'b1};
			repeat (8) @(posedge clk_i);
			chk({strap_pin_high_oe_o, gpio_in_o[1], slow_o}, {~g[0], g[0], 1'b1});
		end
		chk(16'(q_got.size()), 16'(q_exp.size()));
		foreach (q_exp[i]) chk(q_got[i], q_exp[i]);
		chk(16'(n_rd), 16'(n_rde));
		$display("test pins and writes done");
		wrap_up();
	end
endmodule : mtw_target_tb
`default_nettype wire
